//--- verilog/port_status_bank.v
// Per-port status and control register bank for three cable ports, APB slave
`timescale 1ns/1ps
`include "port_status_map.vh"

module port_status_bank #(
    parameter [31:0] DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES  // Attach debounce length
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         irq,
    input  wire [8:0]  port_capability,  // 3 bits per port, maximum speed
    input  wire [2:0]  cable_present,    // Raw connection detect per port
    input  wire [2:0]  signal_present,   // Raw receive signal detect per port
    input  wire [2:0]  b_mode,           // Port running in 1394b mode
    input  wire [2:0]  new_b_connection, // Pulse: new 1394b connection starts
    input  wire [2:0]  speed_neg_fail,   // Pulse: speed negotiation failed
    input  wire [2:0]  sync_fail,        // Pulse: synchronisation failed
    input  wire [2:0]  bad_codeword,     // Pulse: invalid codeword received
    input  wire [2:0]  loop_detected,    // Pulse: loop-free build blocks port
    input  wire [2:0]  standby_state,    // Port in standby power state
    input  wire        bus_reset,        // Pulse: bus reset
    input  wire        remote_read,      // Pulse: remote packet reads error counter
    input  wire [1:0]  remote_port,      // Port addressed by remote read
    output reg  [8:0]  link_speed,       // Speed ceiling in use per connection
    output reg  [2:0]  port_enable,      // Port may become active
    output reg  [2:0]  tone_enable,      // Port keeps toning
    output reg  [2:0]  plug_here_flag,   // Local plug presence per port
    output reg  [2:0]  rx_signal_valid   // Gated receive valid per port
);

    // ****************************************
    // Bus decode
    // ****************************************
    wire        wr_en  = psel & penable & pwrite;           // Write strobe
    wire        rd_en  = psel & penable & ~pwrite;          // Read strobe
    wire [11:0] offset = {paddr[11:2], 2'b00};              // Word address

    // Zero wait states: pready is a flop that rises after reset

    // ****************************************
    // Storage
    // ****************************************
    reg [1:0]  port_sel;        // Selected port index
    reg [2:0]  speed_ceil [0:2];// Software speed ceiling
    reg [2:0]  disable_ctrl;    // Port disable control
    reg [2:0]  deep_off;        // Deep-off control
    reg [2:0]  unreliable;      // Unreliable connection flag
    reg [7:0]  err_count [0:2]; // Invalid codeword counters
    reg [2:0]  loop_block;      // Loop blocked flag
    reg [2:0]  attach;          // Debounced attach flag
    reg [31:0] deb_cnt [0:2];   // Debounce counters
    reg [3:0]  irq_status;      // Sticky events
    reg [3:0]  irq_mask;        // Interrupt enables
    reg        cap_loaded;      // Ceiling loaded from capability
    reg [3:0]  next_irq;        // Events this cycle

    wire [2:0] hard_off = disable_ctrl & deep_off;
    wire [1:0] sel      = (port_sel > 2'd2) ? 2'd0 : port_sel;
    wire [2:0] cap_sel  = port_capability[3*sel +: 3];
    wire [2:0] wr_speed = pwdata[`SC_SPEED_LSB +: 3];

    integer i;

    // ****************************************
    // Per-port state
    // ****************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_sel     <= 2'd0;
            disable_ctrl <= 3'h0;
            deep_off     <= 3'h0;
            unreliable   <= 3'h0;
            loop_block   <= 3'h0;
            attach       <= 3'h0;
            cap_loaded   <= 1'b0;
            link_speed   <= 9'h000;
            for (i = 0; i < 3; i = i + 1) begin
                speed_ceil[i] <= 3'h0;
                err_count[i]  <= 8'h00;
                deb_cnt[i]    <= 32'h0;
            end
        end else begin
            // Ceiling defaults to capability after power reset
            if (!cap_loaded) begin
                cap_loaded <= 1'b1;
                for (i = 0; i < 3; i = i + 1) begin
                    speed_ceil[i] <= port_capability[3*i +: 3];
                end
            end
            // Port select register
            if (wr_en && offset == `OFF_PORT_SELECT) begin
                port_sel <= pwdata[1:0];
            end
            for (i = 0; i < 3; i = i + 1) begin
                // Ceiling clamp on write
                if (wr_en && offset == `OFF_SPEED_CTRL && sel == i) begin
                    if (wr_speed > port_capability[3*i +: 3]) begin
                        speed_ceil[i] <= port_capability[3*i +: 3];
                    end else begin
                        speed_ceil[i] <= wr_speed;
                    end
                    disable_ctrl[i] <= pwdata[`SC_DISABLE_BIT];
                    deep_off[i]     <= pwdata[`SC_DEEP_OFF_BIT];
                end
                // Ceiling captured only on new 1394b connection
                if (new_b_connection[i]) begin
                    link_speed[3*i +: 3] <= speed_ceil[i];
                end
                // Unreliable flag, set wins over clear
                if (speed_neg_fail[i] || sync_fail[i]) begin
                    unreliable[i] <= 1'b1;
                end else if (wr_en && offset == `OFF_SPEED_CTRL && sel == i
                             && pwdata[`SC_UNRELIABLE_BIT]) begin
                    unreliable[i] <= 1'b0;
                end
                // Error counter: a bus read removes only what it reported
                if (rd_en && offset == `OFF_ERROR_COUNT && sel == i) begin
                    err_count[i] <= err_count[i] - prdata[7:0]
                                    + {7'h0, bad_codeword[i]};
                end else if (bad_codeword[i]) begin
                    if (err_count[i] != `ERR_COUNT_MAX) begin
                        err_count[i] <= err_count[i] + 8'h01;
                    end
                end else if (remote_read && remote_port == i) begin
                    err_count[i] <= 8'h00;
                end
                // Loop blocked flag
                if (loop_detected[i]) begin
                    loop_block[i] <= 1'b1;
                end else if (bus_reset || !attach[i]) begin
                    loop_block[i] <= 1'b0;
                end
                // Attach debounce, bus reset leaves it alone
                if (!cable_present[i] || hard_off[i]) begin
                    deb_cnt[i] <= 32'h0;
                    attach[i]  <= 1'b0;
                end else if (deb_cnt[i] >= DEBOUNCE_CYCLES - 32'h1) begin
                    attach[i]  <= 1'b1;
                end else begin
                    deb_cnt[i] <= deb_cnt[i] + 32'h1;
                end
            end
        end
    end

    // ****************************************
    // Port outputs
    // ****************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_enable     <= 3'h0;
            tone_enable     <= 3'h0;
            plug_here_flag  <= 3'h0;
            rx_signal_valid <= 3'h0;
        end else begin
            port_enable     <= ~disable_ctrl;
            tone_enable     <= ~hard_off;
            plug_here_flag  <= 3'h7;
            rx_signal_valid <= signal_present & ~hard_off;
        end
    end

    // ****************************************
    // Interrupt events
    // ****************************************
    always @* begin
        next_irq = 4'h0;
        for (i = 0; i < 3; i = i + 1) begin
            if (speed_neg_fail[i] || sync_fail[i]) next_irq[`IRQ_UNRELIABLE] = 1'b1;
            if (cable_present[i] && !hard_off[i] && !attach[i]
                && deb_cnt[i] >= DEBOUNCE_CYCLES - 32'h1) next_irq[`IRQ_ATTACH] = 1'b1;
            if (loop_detected[i]) next_irq[`IRQ_LOOP] = 1'b1;
            if (bad_codeword[i] && err_count[i] == 8'hfe) next_irq[`IRQ_ERR_SAT] = 1'b1;
        end
    end

    // Sticky status cleared by read, events win
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= 4'h0;
            irq_mask   <= 4'h0;
            irq        <= 1'b0;
        end else begin
            if (rd_en && offset == `OFF_IRQ_STATUS) begin
                // Clear only bits reported, so a setup-cycle event survives
                irq_status <= (irq_status & ~prdata[3:0]) | next_irq;
            end else begin
                irq_status <= irq_status | next_irq;
            end
            if (wr_en && offset == `OFF_IRQ_MASK) begin
                irq_mask <= pwdata[3:0];
            end
            irq <= |(irq_status & irq_mask);
        end
    end

    // ****************************************
    // Read data and error response
    // ****************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pslverr <= 1'b0;
            pready  <= 1'b0;
        end else begin
            pready  <= 1'b1;                                // Always ready
            prdata  <= 32'h0;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                case (offset)
                    `OFF_PORT_SELECT: begin
                        prdata <= {30'h0, port_sel};
                    end
                    `OFF_SPEED_CTRL: begin
                        prdata <= {23'h0, unreliable[sel], 2'b00, deep_off[sel],
                                   disable_ctrl[sel], 1'b0, speed_ceil[sel]};
                    end
                    `OFF_PORT_STATUS: begin
                        prdata <= {17'h0, link_speed[3*sel +: 3], 1'b0,
                                   attach[sel] & signal_present[sel] & ~hard_off[sel]
                                   & ~b_mode[sel],
                                   standby_state[sel],
                                   loop_block[sel],
                                   rx_signal_valid[sel], attach[sel],
                                   b_mode[sel],
                                   1'b1, 1'b0, cap_sel};
                    end
                    `OFF_ERROR_COUNT: begin
                        prdata <= {24'h0, err_count[sel]};
                    end
                    `OFF_IRQ_STATUS: begin
                        prdata <= {28'h0, irq_status};
                    end
                    `OFF_IRQ_MASK: begin
                        prdata <= {28'h0, irq_mask};
                    end
                    default: begin
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Usage notes
    // ****************************************
    // Bus timing
    // - Read data is built in the setup cycle.
    // - It stands for the access cycle only.
    // - Outside an access cycle prdata is zero.
    // - pslverr marks an unmapped word address.
    // - Writes take effect at the access edge.
    // - The two low address bits are ignored.
    // - Back to back transfers are accepted.
    // - pready is low only while in reset.
    //
    // Port selection
    // - Every per-port field follows port_sel.
    // - A select value of three maps to port 0.
    // - Remote reads name their port directly.
    // - A remote read never uses port_sel.
    //
    // Speed ceiling
    // - Loaded from capability after reset.
    // - The load happens on the first edge.
    // - Writes above capability store capability.
    // - Lower values force slower training.
    // - Software keeps it above the minimum.
    // - Hardware does not police the minimum.
    // - The value in use is link_speed.
    // - link_speed moves only on a new connection.
    // - A changed ceiling waits for reconnection.
    // - Reserved codes are stored only if port_capability holds one.
    //
    // Speed control word
    // - Each write updates ceiling and both
    //   disable controls together.
    // - Software must read, modify and write.
    // - The unreliable bit clears on a one.
    // - Writing zero there leaves it alone.
    // - A failure in the same cycle wins.
    //
    // Error counter
    // - Counts invalid codewords per port.
    // - Holds at its top value; a remote clear in a bus read's setup cycle makes it wrap.
    // - A bus read subtracts what it returned.
    // - So a codeword arriving during the read
    //   is never lost.
    // - A remote read clears the count fully.
    // - An increment beats a remote clear.
    //
    // Interrupts
    // - Status bits are sticky.
    // - A status read clears reported bits only.
    // - Events in the read cycle stay pending.
    // - irq lags the status by one cycle.
    // - A zero mask keeps irq low.
    // - Bit 0 marks an unreliable connection.
    // - Bit 1 marks a new debounced attach.
    // - Bit 2 marks a loop block.
    // - Bit 3 marks the counter reaching its top.
    //
    // Attach debounce
    // - The cable must stay present throughout.
    // - Any drop restarts the count.
    // - The hard-off state also restarts it.
    // - Bus reset leaves attach untouched.
    // - Hard reset clears it.
    // - The count is a parameter for testing.
    // - Its default spans the full settle time.
    //
    // Loop block
    // - Set by the loop-free build event.
    // - Cleared by bus reset.
    // - Cleared while the port is detached.
    // - A set in the same cycle wins.
    //
    // Disable controls
    // - Disable alone stops the port going active.
    // - The port keeps toning while disabled.
    // - Deep-off alone has no effect at all.
    // - Both together stop toning as well.
    // - Both together force attach low.
    // - Both together force rx valid low.
    // - This is how software forces a new
    //   speed negotiation on a connection.
    // - It also saves power on idle ports.
    // - Hard reset clears both controls.
    // - Bus reset does not touch them.
    //
    // Status word
    // - The plug flag always reads one.
    // - Capability comes straight from the pins.
    // - The 1394a active bit needs attach,
    //   rx valid and not 1394b mode.
    // - The standby bit follows its pin.
    //
    // Hazards
    // - port_capability must be stable from reset.
    // - A capability change is not re-clamped.
    // - Event pins are one-cycle pulses.
    // - A longer pulse counts once per cycle.

endmodule

//--- verilog/port_status_map.vh
// Register offsets, field positions, reset values and timing counts for the port status bank
`ifndef PORT_STATUS_MAP_VH
`define PORT_STATUS_MAP_VH

// ****************************************
// Register byte offsets
// ****************************************
`define OFF_PORT_SELECT   12'h000
`define OFF_SPEED_CTRL    12'h004
`define OFF_PORT_STATUS   12'h008
`define OFF_ERROR_COUNT   12'h00c
`define OFF_IRQ_STATUS    12'h010
`define OFF_IRQ_MASK      12'h014

// ****************************************
// Field positions in speed/control register
// ****************************************
`define SC_SPEED_LSB      0
`define SC_DISABLE_BIT    4
`define SC_DEEP_OFF_BIT   5
`define SC_UNRELIABLE_BIT 8

// ****************************************
// Field positions in port status register
// ****************************************
`define PS_CAP_LSB        0
`define PS_PLUG_BIT       4
`define PS_B_ACTIVE_BIT   5
`define PS_ATTACH_BIT     6
`define PS_RX_VALID_BIT   7
`define PS_LOOP_BIT       8
`define PS_STANDBY_BIT    9
`define PS_A_ACTIVE_BIT   10
`define PS_NEG_LSB        12

// ****************************************
// Interrupt status bits
// ****************************************
`define IRQ_UNRELIABLE    0
`define IRQ_ATTACH        1
`define IRQ_LOOP          2
`define IRQ_ERR_SAT       3

// ****************************************
// Speed codes and reset values
// ****************************************
`define SPEED_S100        3'h0
`define SPEED_S200        3'h1
`define SPEED_S400        3'h2
`define SPEED_S800        3'h3
`define SPEED_S1600       3'h4
`define SPEED_S3200       3'h5
`define ERR_COUNT_MAX     8'hff
`define PORT_CAP_DEFAULT  9'h0db

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS     100
`define DEBOUNCE_MS       341
`define DEBOUNCE_CYCLES   ((`DEBOUNCE_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- sim/port_status_props.sv
// Concurrent checks on the port status bank ports
`timescale 1ns/1ps
module port_status_props (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire        pslverr,
    input wire [8:0]  port_capability,
    input wire [2:0]  signal_present,
    input wire [2:0]  new_b_connection,
    input wire [8:0]  link_speed,
    input wire [2:0]  port_enable,
    input wire [2:0]  tone_enable,
    input wire [2:0]  plug_here_flag,
    input wire [2:0]  rx_signal_valid
);
    // ****************************************
    // Clock and reset of all checks
    // ****************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_plug_always: assert property ($past(presetn) |-> plug_here_flag == 3'h7)
        else $error("plug flag not all ones");
    chk_plug_read: assert property (psel && penable && !pwrite && paddr == 12'h008
        |-> prdata[4:3] == 2'h2) else $error("status plug bits wrong");
    chk_link_hold: assert property (!$stable(link_speed)
        |-> $past(new_b_connection) != 3'h0) else $error("ceiling moved mid connection");
    chk_link_cap: assert property (link_speed[2:0] <= port_capability[2:0]
        && link_speed[5:3] <= port_capability[5:3]
        && link_speed[8:6] <= port_capability[8:6]) else $error("ceiling above capability");
    chk_code_range: assert property (link_speed[2:0] < 3'h6 && link_speed[5:3] < 3'h6
        && link_speed[8:6] < 3'h6) else $error("reserved speed code in use");
    chk_deep_gate: assert property ((~tone_enable & port_enable) == 3'h0)
        else $error("deep off acted on enabled port");
    chk_rx_gated: assert property ((rx_signal_valid & ~tone_enable) == 3'h0)
        else $error("rx valid while hard off");
    chk_rx_source: assert property ((rx_signal_valid & ~$past(signal_present)) == 3'h0)
        else $error("rx valid without signal");
    chk_slverr_one: assert property (pslverr |-> (psel && penable) ##1 !pslverr)
        else $error("error response outside access");
    chk_hard_reset: assert property (!$past(presetn) |=> port_enable == 3'h7
        && tone_enable == 3'h7) else $error("ports not enabled after reset");
    // Main scenarios reached
    cover property (pslverr);
    cover property (!$stable(link_speed));
    cover property (tone_enable != 3'h7);
endmodule
bind port_status_bank port_status_props chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .port_capability(port_capability),
    .signal_present(signal_present), .new_b_connection(new_b_connection),
    .link_speed(link_speed), .port_enable(port_enable), .tone_enable(tone_enable),
    .plug_here_flag(plug_here_flag), .rx_signal_valid(rx_signal_valid)
);

//--- sim/port_side_model.sv
// Cable port side model: line levels and port events held for n cycles
`timescale 1ns/1ps
module port_side_model (
    input  wire       pclk,
    output reg  [2:0] cable_present,
    output reg  [2:0] signal_present,
    output reg  [2:0] b_mode,
    output reg  [2:0] standby_state,
    output reg  [2:0] ev_new,
    output reg  [2:0] ev_neg,
    output reg  [2:0] ev_sync,
    output reg  [2:0] ev_bad,
    output reg  [2:0] ev_loop,
    output reg        bus_reset,
    output reg        remote_read,
    output reg  [1:0] remote_port
);
    // ****************************************
    // Idle line state: nothing attached
    // ****************************************
    initial begin
        {cable_present, signal_present, b_mode, standby_state} = 12'h000;
        {ev_new, ev_neg, ev_sync, ev_bad, ev_loop} = 15'h0000;
        {bus_reset, remote_read, remote_port} = 4'h0;
    end
    // Raise event kind k on ports p for n cycles
    task automatic pulse(input integer k, input [2:0] p, input integer n);
        begin
            @(posedge pclk);
            case (k)
                0: ev_new <= p;
                1: ev_neg <= p;
                2: ev_sync <= p;
                3: ev_bad <= p;
                4: ev_loop <= p;
                5: bus_reset <= 1'b1;
                default: remote_read <= 1'b1;
            endcase
            repeat (n) @(posedge pclk);
            {ev_new, ev_neg, ev_sync, ev_bad, ev_loop} <= 15'h0000;
            {bus_reset, remote_read} <= 2'h0;
        end
    endtask
endmodule

//--- sim/port_status_bank_bench.sv
// Self-checking bench for the port status bank over APB
`timescale 1ns/1ps
module port_status_bank_bench;
    reg         pclk = 1'b0;    // Bus clock
    reg         presetn = 1'b0; // Reset, active low
    reg         psel = 1'b0;    // APB request
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0;
    reg  [8:0]  cap = 9'h0db;   // All ports reach code 3
    wire [31:0] prdata;
    wire        pready, pslverr, irq, bus_reset, remote_read;
    wire [8:0]  link_speed;
    wire [2:0]  port_enable, tone_enable, plug_here_flag, rx_signal_valid;
    wire [2:0]  cab, sig, bm, sb, e_new, e_neg, e_sync, e_bad, e_loop;
    wire [1:0]  rport;
    integer     err_count = 0, total_checks = 0, cycles = 0, i;
    reg  [31:0] q;
    reg         e;
    always #50 pclk = ~pclk;
    port_side_model m_u (.pclk(pclk), .cable_present(cab), .signal_present(sig), .b_mode(bm),
        .standby_state(sb), .ev_new(e_new), .ev_neg(e_neg), .ev_sync(e_sync), .ev_bad(e_bad),
        .ev_loop(e_loop), .bus_reset(bus_reset), .remote_read(remote_read), .remote_port(rport));
    port_status_bank #(.DEBOUNCE_CYCLES(32'd8)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .port_capability(cap), .cable_present(cab), .signal_present(sig), .b_mode(bm),
        .new_b_connection(e_new), .speed_neg_fail(e_neg), .sync_fail(e_sync),
        .bad_codeword(e_bad), .loop_detected(e_loop), .standby_state(sb),
        .bus_reset(bus_reset), .remote_read(remote_read), .remote_port(rport),
        .link_speed(link_speed), .port_enable(port_enable), .tone_enable(tone_enable),
        .plug_here_flag(plug_here_flag), .rx_signal_valid(rx_signal_valid));
    // ****************************************
    // Report and bus tasks
    // ****************************************
    task test_done;
        begin
            $display("checks %0d errors %0d", total_checks, err_count);
            if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    task chk(input string n, input [31:0] x, input [31:0] g);
        begin
            total_checks = total_checks + 1;
            if (g !== x) begin
                err_count = err_count + 1;
                $display("ERROR %s expected %h seen %h", n, x, g);
            end
        end
    endtask
    // One APB transfer, held until pready is seen
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) @(posedge pclk);
            q = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task rdc(input string n, input [11:0] a, input [31:0] m, input [31:0] x);
        begin
            apb(1'b0, a, 32'h0);
            chk(n, x, q & m);
        end
    endtask
    // Hang guard
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            err_count = err_count + 1;
            test_done;
        end
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc("status", 12'h008, 32'h1f, 32'h13);
        rdc("ceiling", 12'h004, 32'h7, 32'h3);
        for (i = 0; i < 8; i = i + 1) begin
            apb(1'b1, 12'h004, i);
            rdc("ceiling", 12'h004, 32'h7, (i > 3) ? 3 : i);
        end
        apb(1'b1, 12'h004, 32'h1);
        m_u.pulse(0, 3'h1, 1);
        apb(1'b1, 12'h004, 32'h2);
        chk("link", 32'h1, link_speed);
        apb(1'b1, 12'h014, 32'hf);
        m_u.pulse(2, 3'h1, 1);
        repeat (3) @(posedge pclk);
        chk("irq", 32'h1, irq);
        rdc("unrel", 12'h004, 32'h100, 32'h100);
        apb(1'b1, 12'h004, 32'h102);
        rdc("unrel", 12'h004, 32'h100, 32'h0);
        rdc("irqsts", 12'h010, 32'hf, 32'h1);
        rdc("irqsts", 12'h010, 32'hf, 32'h0);
        chk("irq", 32'h0, irq);
        apb(1'b1, 12'h014, 32'h0);
        m_u.pulse(1, 3'h1, 1);
        repeat (3) @(posedge pclk);
        chk("irq", 32'h0, irq);
        rdc("unrel", 12'h004, 32'h100, 32'h100);
        m_u.pulse(3, 3'h1, 3);
        rdc("errcnt", 12'h00c, 32'hff, 32'h3);
        rdc("errcnt", 12'h00c, 32'hff, 32'h0);
        m_u.pulse(3, 3'h1, 260);
        rdc("errcnt", 12'h00c, 32'hff, 32'hff);
        m_u.pulse(3, 3'h1, 2);
        m_u.pulse(6, 3'h0, 1);
        rdc("errcnt", 12'h00c, 32'hff, 32'h0);
        apb(1'b1, 12'h000, 32'h1);
        m_u.pulse(3, 3'h2, 2);
        rdc("errcnt", 12'h00c, 32'hff, 32'h2);
        apb(1'b1, 12'h000, 32'h0);
        m_u.cable_present <= 3'h1;
        m_u.signal_present <= 3'h1;
        rdc("attach", 12'h008, 32'h40, 32'h0);
        repeat (12) @(posedge pclk);
        rdc("status", 12'h008, 32'h4e0, 32'h4c0);
        m_u.b_mode <= 3'h1;
        rdc("status", 12'h008, 32'h420, 32'h20);
        m_u.pulse(4, 3'h1, 1);
        rdc("loop", 12'h008, 32'h100, 32'h100);
        m_u.pulse(5, 3'h0, 1);
        rdc("loop", 12'h008, 32'h140, 32'h40);
        m_u.pulse(4, 3'h1, 1);
        m_u.standby_state <= 3'h1;
        rdc("standby", 12'h008, 32'h300, 32'h300);
        apb(1'b1, 12'h004, 32'h23);
        repeat (2) @(posedge pclk);
        chk("enables", 32'h3f, {port_enable, tone_enable});
        apb(1'b1, 12'h004, 32'h13);
        repeat (2) @(posedge pclk);
        chk("enables", 32'h37, {port_enable, tone_enable});
        apb(1'b1, 12'h004, 32'h33);
        repeat (2) @(posedge pclk);
        chk("enables", 32'h36, {port_enable, tone_enable});
        chk("rxvalid", 32'h0, rx_signal_valid);
        rdc("hardoff", 12'h008, 32'h1c0, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        chk("slverr", 32'h1, e);
        test_done;
    end
endmodule
